// ### i2c_slave_engine.sv
// Two-wire slave byte transfer engine with an APB register port
`timescale 1ns/10ps
`include "i2c_slave_consts.svh"

module i2c_slave_engine #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [ADDR_W-1:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic scl_i, // Clock line level
   output logic scl_o, // Clock line drive value
   output logic scl_oe_n, // Clock line drive enable
   input wire logic sda_i, // Data line level
   output logic sda_o, // Data line drive value
   output logic sda_oe_n, // Data line drive enable
   output logic irq // Interrupt request
);

   i2c_slave_pkg::state_t q;
   i2c_slave_pkg::state_t d;

   function automatic logic [31:0] read_mux(
      input i2c_slave_pkg::state_t s,
      input logic [ADDR_W-1:0] a
   );
      logic [31:0] r;
      r = 32'h0;
      case (a)
         ADDR_W'(`CTRL_OFS): begin
            r[`CTRL_IRQ_EN_BIT] = s.irq_en;
            r[`CTRL_STOP_BIT] = s.stop_req;
            r[`CTRL_ACK_EN_BIT] = s.ack_en;
         end
         ADDR_W'(`STAT1_OFS): begin
            r[`STAT1_EVENT_BIT] = s.any_event;
            r[`STAT1_TRA_BIT] = s.tra;
            r[`STAT1_BUSY_BIT] = s.busy;
            r[`STAT1_BYTE_BIT] = s.byte_done;
            r[`STAT1_ADDR_BIT] = s.addr_f;
            r[`STAT1_MASTER_BIT] = 1'b0;
            r[`STAT1_START_SENT_BIT] = 1'b0;
         end
         ADDR_W'(`STAT2_OFS): begin
            r[`STAT2_NACK_BIT] = s.nack_seen;
            r[`STAT2_STOP_BIT] = s.stop_seen;
            r[`STAT2_FAULT_BIT] = s.bus_fault;
         end
         ADDR_W'(`DATA_OFS): r[7:0] = s.data_byte;
         ADDR_W'(`OWN_ADDR_OFS): r[6:0] = s.own_addr;
         default: r = 32'h0;
      endcase
      return r;
   endfunction : read_mux

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == ADDR_W'(`CTRL_OFS)) || (a == ADDR_W'(`STAT1_OFS)) ||
         (a == ADDR_W'(`STAT2_OFS)) || (a == ADDR_W'(`DATA_OFS)) ||
         (a == ADDR_W'(`OWN_ADDR_OFS));
   endfunction : is_mapped

   always_comb begin
      logic rise;
      logic fall;
      logic start_c;
      logic stop_c;
      logic mid_byte;
      logic done;
      logic rd_stat1;
      logic rd_stat2;
      logic rd_data;
      logic wr_data;
      logic wr_ctrl;
      logic [7:0] nsh;
      rise = 1'b0;
      fall = 1'b0;
      start_c = 1'b0;
      stop_c = 1'b0;
      mid_byte = 1'b0;
      done = 1'b0;
      rd_stat1 = 1'b0;
      rd_stat2 = 1'b0;
      rd_data = 1'b0;
      wr_data = 1'b0;
      wr_ctrl = 1'b0;
      nsh = 8'h00;
      d = q;

      // Two-stage synchronisers, third stage only for edge finding
      d.scl_m = scl_i;
      d.scl_s = q.scl_m;
      d.scl_p = q.scl_s;
      d.sda_m = sda_i;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      rise = q.scl_s & ~q.scl_p;
      fall = ~q.scl_s & q.scl_p;
      start_c = q.scl_s & q.scl_p & ~q.sda_s & q.sda_p;
      stop_c = q.scl_s & q.scl_p & q.sda_s & ~q.sda_p;
      // A rise alone is no finished bit: a stop may still follow it
      mid_byte = ((q.ph == i2c_slave_pkg::PH_ADDR ||
         q.ph == i2c_slave_pkg::PH_RX) && (q.cnt > 4'h1)) ||
         ((q.ph == i2c_slave_pkg::PH_TX) && (q.cnt != 4'h0));

      // APB: one wait state, side effects at the completing edge
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      if (psel && penable && !q.pready) begin
         d.pready = 1'b1;
         d.pslverr = ~is_mapped(paddr);
         d.prdata = pwrite ? 32'h0 : read_mux(q, paddr);
      end
      done = psel & penable & q.pready;
      rd_stat1 = done & ~pwrite & (paddr == ADDR_W'(`STAT1_OFS));
      rd_stat2 = done & ~pwrite & (paddr == ADDR_W'(`STAT2_OFS));
      rd_data = done & ~pwrite & (paddr == ADDR_W'(`DATA_OFS));
      wr_data = done & pwrite & (paddr == ADDR_W'(`DATA_OFS));
      wr_ctrl = done & pwrite & (paddr == ADDR_W'(`CTRL_OFS));

      if (wr_ctrl) begin
         d.irq_en = pwdata[`CTRL_IRQ_EN_BIT];
         d.ack_en = pwdata[`CTRL_ACK_EN_BIT];
         d.stop_req = pwdata[`CTRL_STOP_BIT];
         if (q.stop_req && !pwdata[`CTRL_STOP_BIT] && q.byte_done)
            d.rel = 1'b1;
      end
      if (done && pwrite && paddr == ADDR_W'(`OWN_ADDR_OFS))
         d.own_addr = pwdata[6:0];

      // Status-then-data sequencer
      if (rd_stat1) begin
         d.addr_f = 1'b0;
         if (q.byte_done || q.need_wr)
            d.seq = 1'b1;
      end
      if (rd_data && q.seq && !q.tra) begin
         d.byte_done = 1'b0;
         d.seq = 1'b0;
      end
      if (wr_data) begin
         d.data_byte = pwdata[7:0];
         if (q.seq && q.tra) begin
            d.byte_done = 1'b0;
            d.need_wr = 1'b0;
            d.seq = 1'b0;
            // First bit set up while the clock is still held
            if (q.hold)
               d.sda_drv = ~pwdata[7];
         end
      end
      if (rd_stat2) begin
         d.nack_seen = 1'b0;
         d.bus_fault = 1'b0;
         d.stop_seen = 1'b0;
         if (q.stop_seen)
            d.busy = 1'b0;
      end

      // Link engine; its flag sets come after and so win over clears
      if (stop_c) begin
         if (mid_byte)
            d.bus_fault = 1'b1;
         else if (q.busy)
            d.stop_seen = 1'b1;
         d.ph = i2c_slave_pkg::PH_IDLE;
         d.cnt = 4'h0;
         d.hold = 1'b0;
         d.sda_drv = 1'b0;
         d.need_wr = 1'b0;
         d.seq = 1'b0;
      end else if (start_c) begin
         if (mid_byte)
            d.bus_fault = 1'b1;
         d.ph = i2c_slave_pkg::PH_ADDR;
         d.cnt = 4'h0;
         d.hold = 1'b0;
         d.sda_drv = 1'b0;
         d.need_wr = 1'b0;
         d.seq = 1'b0;
      end else begin
         case (q.ph)
            i2c_slave_pkg::PH_IDLE: begin
               d.sda_drv = 1'b0;
               d.hold = 1'b0;
            end
            i2c_slave_pkg::PH_ADDR: begin
               if (rise) begin
                  nsh = {q.sh[6:0], q.sda_s};
                  d.sh = nsh;
                  d.cnt = q.cnt + 4'h1;
                  if (q.cnt == 4'h7) begin
                     d.cnt = 4'h0;
                     if (nsh[7:1] == q.own_addr) begin
                        d.tra = nsh[0];
                        d.busy = 1'b1;
                        d.ph = i2c_slave_pkg::PH_AACK;
                     end else begin
                        d.ph = i2c_slave_pkg::PH_IDLE;
                     end
                  end
               end
            end
            i2c_slave_pkg::PH_AACK: begin
               if (fall && q.cnt == 4'h0) begin
                  d.sda_drv = 1'b1;
                  d.cnt = 4'h1;
               end else if (fall) begin
                  d.sda_drv = 1'b0;
                  d.addr_f = 1'b1;
                  d.need_wr = q.tra;
                  d.hold = 1'b1;
                  d.cnt = 4'h0;
                  d.ph = i2c_slave_pkg::PH_HOLD;
               end
            end
            i2c_slave_pkg::PH_RX: begin
               if (rise) begin
                  nsh = {q.sh[6:0], q.sda_s};
                  d.sh = nsh;
                  d.cnt = q.cnt + 4'h1;
                  if (q.cnt == 4'h7) begin
                     d.data_byte = nsh;
                     d.cnt = 4'h0;
                     d.ph = i2c_slave_pkg::PH_RACK;
                  end
               end
            end
            i2c_slave_pkg::PH_RACK: begin
               if (fall && q.cnt == 4'h0) begin
                  d.sda_drv = q.ack_en;
                  d.cnt = 4'h1;
               end else if (fall) begin
                  d.sda_drv = 1'b0;
                  d.byte_done = 1'b1;
                  d.cnt = 4'h0;
                  if (q.rel) begin
                     d.rel = 1'b0;
                     d.ph = i2c_slave_pkg::PH_IDLE;
                  end else begin
                     d.hold = 1'b1;
                     d.ph = i2c_slave_pkg::PH_HOLD;
                  end
               end
            end
            i2c_slave_pkg::PH_TX: begin
               if (fall) begin
                  d.cnt = q.cnt + 4'h1;
                  nsh = {q.sh[6:0], 1'b0};
                  d.sh = nsh;
                  d.sda_drv = ~nsh[7];
                  if (q.cnt == 4'h7) begin
                     d.sda_drv = 1'b0;
                     d.cnt = 4'h0;
                     d.ph = i2c_slave_pkg::PH_TACK;
                  end
               end
            end
            i2c_slave_pkg::PH_TACK: begin
               if (rise && q.cnt == 4'h0)
                  d.cnt = q.sda_s ? 4'h2 : 4'h1;
               if (q.scl_s && q.sda_s && q.cnt != 4'h1)
                  d.nack_seen = 1'b1;
               if (fall && q.cnt == 4'h1) begin
                  d.byte_done = 1'b1;
                  d.cnt = 4'h0;
                  if (q.rel) begin
                     d.rel = 1'b0;
                     d.ph = i2c_slave_pkg::PH_IDLE;
                  end else begin
                     d.hold = 1'b1;
                     d.need_wr = 1'b1;
                     d.ph = i2c_slave_pkg::PH_HOLD;
                  end
               end else if (fall && q.cnt == 4'h2) begin
                  d.cnt = 4'h0;
                  d.ph = i2c_slave_pkg::PH_IDLE;
               end
            end
            i2c_slave_pkg::PH_HOLD: begin
               if (q.rel) begin
                  d.rel = 1'b0;
                  d.hold = 1'b0;
                  d.ph = i2c_slave_pkg::PH_IDLE;
               end else if (!q.addr_f && !q.byte_done && !q.need_wr) begin
                  d.hold = 1'b0;
                  d.cnt = 4'h0;
                  if (q.tra) begin
                     d.sh = q.data_byte;
                     d.sda_drv = ~q.data_byte[7];
                     d.ph = i2c_slave_pkg::PH_TX;
                  end else begin
                     d.ph = i2c_slave_pkg::PH_RX;
                  end
               end
            end
            default: begin
               d.ph = i2c_slave_pkg::PH_IDLE;
               d.hold = 1'b0;
               d.sda_drv = 1'b0;
            end
         endcase
      end

      d.any_event = d.addr_f | d.byte_done | d.stop_seen | d.bus_fault |
         d.nack_seen;
      d.irq = d.any_event & d.irq_en;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.scl_m <= 1'b1;
         q.scl_s <= 1'b1;
         q.scl_p <= 1'b1;
         q.sda_m <= 1'b1;
         q.sda_s <= 1'b1;
         q.sda_p <= 1'b1;
         q.ph <= i2c_slave_pkg::PH_IDLE;
         q.data_byte <= `DATA_RESET;
         q.own_addr <= `OWN_ADDR_RESET;
         {q.ack_en, q.stop_req, q.irq_en} <= `CTRL_RESET;
      end else begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_n = ~q.hold;
   assign sda_oe_n = ~q.sda_drv;
   assign irq = q.irq;

endmodule : i2c_slave_engine

// ### i2c_slave_consts.svh
// Register offsets, field positions and reset values of the slave engine
`ifndef I2C_SLAVE_CONSTS_SVH
`define I2C_SLAVE_CONSTS_SVH

`define CTRL_OFS 8'h00
`define STAT1_OFS 8'h04
`define STAT2_OFS 8'h08
`define DATA_OFS 8'h0c
`define OWN_ADDR_OFS 8'h10

`define CTRL_IRQ_EN_BIT 0
`define CTRL_STOP_BIT 1
`define CTRL_ACK_EN_BIT 2

`define STAT1_START_SENT_BIT 0
`define STAT1_MASTER_BIT 1
`define STAT1_ADDR_BIT 2
`define STAT1_BYTE_BIT 3
`define STAT1_BUSY_BIT 4
`define STAT1_TRA_BIT 5
`define STAT1_EVENT_BIT 7

`define STAT2_FAULT_BIT 1
`define STAT2_STOP_BIT 3
`define STAT2_NACK_BIT 4

`define CTRL_RESET 3'h0
`define OWN_ADDR_RESET 7'h00
`define DATA_RESET 8'h00

`endif

// ### i2c_slave_pkg.sv
// Types of the two-wire slave transfer engine
package i2c_slave_pkg;

   typedef enum logic [7:0] {
      PH_IDLE = 8'h01,
      PH_ADDR = 8'h02,
      PH_AACK = 8'h04,
      PH_RX = 8'h08,
      PH_RACK = 8'h10,
      PH_TX = 8'h20,
      PH_TACK = 8'h40,
      PH_HOLD = 8'h80
   } phase_t;

   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic scl_p;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      phase_t ph;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] data_byte;
      logic irq_en;
      logic stop_req;
      logic ack_en;
      logic [6:0] own_addr;
      logic tra;
      logic busy;
      logic addr_f;
      logic byte_done;
      logic stop_seen;
      logic bus_fault;
      logic nack_seen;
      logic any_event;
      logic need_wr;
      logic seq;
      logic rel;
      logic hold;
      logic sda_drv;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_t;

endpackage : i2c_slave_pkg

// ### i2c_slave_engine_assertions.sv
// Port-level checks of the two-wire slave engine
`timescale 1ns/10ps
module i2c_slave_engine_assertions #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Direction
   input wire logic [ADDR_W-1:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic scl_i, // Clock line
   input wire logic scl_o, // Clock drive
   input wire logic scl_oe_n, // Clock enable
   input wire logic sda_i, // Data line
   input wire logic sda_o, // Data drive
   input wire logic sda_oe_n, // Data enable
   input wire logic irq // Interrupt
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic mapped;
   assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      !pready ##1 pready;
   endsequence
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than a cycle");
   ready_wait_a: assert property (setup_s |=> answer_s)
      else $error("pready not after one wait state");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   err_unmapped_a: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr wrong for address");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   open_drain_a: assert property (!scl_o && !sda_o)
      else $error("line drive value not low");
   stretch_low_a: assert property (!scl_oe_n |-> !scl_i)
      else $error("clock line high while held");
   data_release_a: assert property (
      pready && paddr == 8'h0c && !scl_oe_n |-> ##[1:2] scl_oe_n)
      else $error("clock not freed after data access");
   release_cause_a: assert property (
      $rose(scl_oe_n) |-> $past(pready) || $past(pready, 2))
      else $error("clock freed without an access");
   sda_low_a: assert property ($changed(sda_oe_n) |-> !scl_i)
      else $error("data drive moved while clock high");
endmodule : i2c_slave_engine_assertions
bind i2c_slave_engine i2c_slave_engine_assertions #(.ADDR_W(ADDR_W)) chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_n(sda_oe_n), .irq(irq));

// ### i2c_master_model.sv
// Behavioural two-wire bus master facing the slave engine
`timescale 1ns/10ps
module i2c_master_model (
   input wire logic scl, // Clock line
   input wire logic sda, // Data line
   output logic scl_rel, // High frees clock
   output logic sda_rel // High frees data
);
   initial begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic bit_x(input logic b, output logic r);
      #100 sda_rel = b;
      #100 scl_rel = 1'b1;
      wait (scl === 1'b1);
      #200 r = sda;
      scl_rel = 1'b0;
   endtask : bit_x
   task automatic start_c();
      #100 sda_rel = 1'b1;
      #100 scl_rel = 1'b1;
      #200 sda_rel = 1'b0;
      #200 scl_rel = 1'b0;
   endtask : start_c
   task automatic stop_c();
      #100 sda_rel = 1'b0;
      #100 scl_rel = 1'b1;
      wait (scl === 1'b1);
      #200 sda_rel = 1'b1;
      #200;
   endtask : stop_c
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'b1, r);
      ack = !r;
   endtask : wr_byte
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(!ack, r);
   endtask : rd_byte
endmodule : i2c_master_model

// ### testbench.sv
// Self-checking bench of the two-wire slave engine
`timescale 1ns/10ps
module testbench;
   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic e;
   } row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, scl_oe_n, sda_oe_n, irq, m_scl, m_sda;
   logic scl, sda, k, k2, e;
   logic [7:0] d;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   row_t rows [10] = '{'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h10, 32'h2a, 32'h0, 1'b0},
      '{1'b0, 8'h10, 32'h0, 32'h2a, 1'b0}, '{1'b1, 8'h14, 32'h55, 32'h0, 1'b1},
      '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h00, 32'h5, 32'h0, 1'b0},
      '{1'b0, 8'h00, 32'h0, 32'h5, 1'b0}};
   assign scl = scl_oe_n & m_scl;
   assign sda = sda_oe_n & m_sda;
   i2c_slave_engine dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
      .scl_o(), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(),
      .sda_oe_n(sda_oe_n), .irq(irq));
   i2c_master_model mdl_u (.scl(scl), .sda(sda), .scl_rel(m_scl),
      .sda_rel(m_sda));
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, g, x);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] v);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 50) begin
         fail_count++;
         $display("BAD %0t no answer on register bus", $time);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask : rd
   task automatic wirq();
      int n;
      n = 0;
      repeat (4) @(posedge pclk);
      while (irq !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n < 400), 32'h1);
   endtask : wirq
   initial begin
      repeat (3) @(posedge pclk);
      chk({27'h0, pready, pslverr, scl_oe_n, sda_oe_n, irq}, 32'h6);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(r, rows[i].x);
         chk({31'h0, e}, {31'h0, rows[i].e});
      end
      $display("Register test done");
      fork
         begin
            mdl_u.start_c();
            mdl_u.wr_byte({7'h2a, 1'b0}, k);
            mdl_u.wr_byte(8'ha5, k2);
            mdl_u.stop_c();
         end
         begin
            wirq();
            rd(8'h04, 32'h94);
            wirq();
            chk({31'h0, scl_oe_n}, 32'h0);
            rd(8'h04, 32'h98);
            rd(8'h0c, 32'ha5);
            repeat (3) @(posedge pclk);
            chk({31'h0, scl_oe_n}, 32'h1);
         end
      join
      chk({30'h0, k, k2}, 32'h3);
      rd(8'h08, 32'h08);
      rd(8'h08, 32'h00);
      $display("Receive test done");
      fork
         begin
            mdl_u.start_c();
            mdl_u.wr_byte({7'h2a, 1'b1}, k);
            mdl_u.rd_byte(1'b0, d);
            #2000;
            mdl_u.stop_c();
         end
         begin
            wirq();
            rd(8'h04, 32'hb4);
            apb(1'b1, 8'h0c, 32'h3c);
            wirq();
            wait (scl === 1'b0);
            repeat (4) @(posedge pclk);
            chk({31'h0, scl_oe_n}, 32'h1);
            rd(8'h08, 32'h10);
            rd(8'h08, 32'h00);
         end
      join
      chk({24'h0, d}, 32'h3c);
      rd(8'h08, 32'h08);
      $display("Transmit test done");
      fork
         begin
            repeat (2) begin
               mdl_u.start_c();
               mdl_u.wr_byte({7'h2a, 1'b0}, k);
               repeat (3) mdl_u.bit_x(1'b1, k2);
            end
            mdl_u.stop_c();
         end
         begin
            wirq();
            rd(8'h04, 32'h94);
            wirq();
            rd(8'h08, 32'h02);
            wirq();
            rd(8'h04, 32'h94);
         end
      join
      chk({31'h0, k}, 32'h1);
      rd(8'h08, 32'h02);
      chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
      $display("Bus error test done");
      end_sim();
   end
endmodule : testbench
